//--- src/ncrg_defs.vh
`ifndef NCRG_DEFS_VH
`define NCRG_DEFS_VH

// Command codes seen in command cycles.
`define NCRG_CMD_READ      8'h00
`define NCRG_CMD_READ_CONF 8'h30
`define NCRG_CMD_SERIAL_IN 8'h80
`define NCRG_CMD_COL_CHG   8'h85
`define NCRG_CMD_PROG      8'h10
`define NCRG_CMD_MULTI     8'h11
`define NCRG_CMD_ERASE     8'h60
`define NCRG_CMD_ERASE_CNF 8'hd0
`define NCRG_CMD_STATUS    8'h70
`define NCRG_CMD_STATUS2   8'h71
`define NCRG_CMD_RESET     8'hff

// Status byte bit positions.
`define NCRG_ST_FAIL  0
`define NCRG_ST_RDY_A 5
`define NCRG_ST_RDY_B 6
`define NCRG_ST_WP    7

// Address cycles that are used; further cycles are dropped.
`define NCRG_ADDR_CYCLES 3'h5

// Timing figures in ns and the clock period in ns.
`define NCRG_CLK_NS        4
`define NCRG_INIT_NS       1000
`define NCRG_RST_NS        500
`define NCRG_DISCHARGE_NS  100
`define NCRG_READ_NS       2000
`define NCRG_PROG_NS       4000
`define NCRG_ERASE_NS      8000

// Cycle counts derived from the figures (least times, rounded up).
`define NCRG_CYC(ns) (((ns) + `NCRG_CLK_NS - 1) / `NCRG_CLK_NS)

// ECC limits: correctable bits per unit and unit size in bytes.
`define NCRG_ECC_MAX_BITS 4'h8
`define NCRG_ECC_UNIT     528

`endif

//--- src/ncrg_busy_timer.v
`default_nettype none

// Down counter that times one busy period; a new load restarts it.
module ncrg_busy_timer (
	// Clock and reset.
	input  wire        core_clk_i,
	input  wire        nrst_i,
	// Control.
	input  wire        load_i,
	input  wire [15:0] count_i,
	// State.
	output wire        done_o
);

	reg [15:0] remain; // Cycles left in the current period.

	// A load always wins, so a repeated reset simply restarts the period.
	always @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			remain <= 16'h0000;
		end else if (load_i) begin
			remain <= count_i;
		end else if (remain != 16'h0000) begin
			remain <= remain - 16'h0001;
		end
	end

	assign done_o = (remain == 16'h0000);

endmodule // ncrg_busy_timer

`default_nettype wire

//--- src/ncrg_guard.v
// Behaviour
// - Reset aborts all; discharge then wait.
// - Reset in page copy may abort prior page.
// - During init only FFh and 70h accepted.
// - Busy held low during power-on init.
// - Other code after 80h cancels program; here 70h, 71h and 85h leave serial input pending.
// - Status mode persists until 00h arrives; 80h and FFh also clear it here.
// - 00h resumes output at stopped column.
// - Write protect low aborts program/erase.
// - Sixth address cycle latched but ignored.
// - Partial page programs allowed per segment.
// - Correct eight bits per 528 bytes.
// - Pass/fail valid only once ready again.
`include "ncrg_defs.vh"
`default_nettype none

module ncrg_guard (
	// Clock and reset.
	input  wire        core_clk_i,
	input  wire        nrst_i,
	// Bus cycle strobes from the controller, one cycle each.
	input  wire        cmd_we_i,
	input  wire        addr_we_i,
	input  wire        data_we_i,
	input  wire        data_re_i,
	input  wire [7:0]  io_i,
	input  wire        wp_n_i,
	// Array result inputs.
	input  wire        array_fail_i,
	input  wire [3:0]  ecc_err_bits_i,
	input  wire        ecc_unit_done_i,
	// Outputs to the pins and the array core.
	output reg  [7:0]  io_o,
	output reg         io_oe_o,
	output reg         ready_busy_n_oe_o,
	output reg         hv_enable_o,
	output reg         prog_start_o,
	output reg         erase_start_o,
	output reg         read_start_o,
	output reg  [39:0] addr_o,
	output reg  [11:0] column_o,
	output reg         uncorrectable_o
);

	// Operating states.
	localparam ST_INIT      = 3'd0;
	localparam ST_IDLE      = 3'd1;
	localparam ST_SERIAL_IN = 3'd2;
	localparam ST_PROG      = 3'd3;
	localparam ST_ERASE     = 3'd4;
	localparam ST_READ      = 3'd5;
	localparam ST_DISCHARGE = 3'd6;
	localparam ST_RST_WAIT  = 3'd7;

	// Busy periods in cycles; the integer forms are cut to the timer width on purpose.
	localparam integer INIT_N  = `NCRG_CYC(`NCRG_INIT_NS);
	localparam integer RST_N   = `NCRG_CYC(`NCRG_RST_NS);
	localparam integer DIS_N   = `NCRG_CYC(`NCRG_DISCHARGE_NS);
	localparam integer READ_N  = `NCRG_CYC(`NCRG_READ_NS);
	localparam integer PROG_N  = `NCRG_CYC(`NCRG_PROG_NS);
	localparam integer ERASE_N = `NCRG_CYC(`NCRG_ERASE_NS);
	localparam [15:0] INIT_CYC  = INIT_N[15:0];
	localparam [15:0] RST_CYC   = RST_N[15:0];
	localparam [15:0] DIS_CYC   = DIS_N[15:0];
	localparam [15:0] READ_CYC  = READ_N[15:0];
	localparam [15:0] PROG_CYC  = PROG_N[15:0];
	localparam [15:0] ERASE_CYC = ERASE_N[15:0];

	reg  [2:0]  state;         // Current operating state.
	reg         status_mode;   // Data reads return the status byte.
	reg         data_out_mode; // Reads return page data.
	reg         fail;          // Result of the last program or erase.
	reg         last_was_pe;   // Last operation was program or erase.
	reg         prog_pending;  // Multi page program remembered for copy.
	reg  [2:0]  addr_cnt;      // Address cycles taken in this sequence.
	reg  [39:0] addr_buf;      // First five address cycles.
	reg         tmr_load;      // Starts a busy period.
	reg  [15:0] tmr_count;     // Length of that period.
	reg         init_started;  // Init timer has been loaded once.
	wire        tmr_done;      // Busy period over.
	wire        busy;          // Device is busy.

	// Status byte, pass/fail forced to pass while busy.
	function [7:0] status_byte;
		input b;
		input f;
		input wp;
		begin
			status_byte = 8'h00;
			status_byte[`NCRG_ST_FAIL]  = f & ~b;
			status_byte[`NCRG_ST_RDY_A] = ~b;
			status_byte[`NCRG_ST_RDY_B] = ~b;
			status_byte[`NCRG_ST_WP]    = wp;
		end
	endfunction

	// Codes the device accepts while busy or initialising.
	function busy_ok;
		input [7:0] c;
		input       in_init;
		begin
			busy_ok = (c == `NCRG_CMD_STATUS) || (c == `NCRG_CMD_RESET) ||
			          (!in_init && c == `NCRG_CMD_STATUS2);
		end
	endfunction

	assign busy = (state != ST_IDLE) && (state != ST_SERIAL_IN);

	ncrg_busy_timer u_timer (
		.core_clk_i (core_clk_i),
		.nrst_i     (nrst_i),
		.load_i     (tmr_load),
		.count_i    (tmr_count),
		.done_o     (tmr_done)
	);

	// Main sequencer: command decode, busy periods and aborts.
	always @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state         <= ST_INIT;
			status_mode   <= 1'b0;
			data_out_mode <= 1'b0;
			fail          <= 1'b0;
			last_was_pe   <= 1'b0;
			prog_pending  <= 1'b0;
			addr_cnt      <= 3'd0;
			addr_buf      <= 40'h0000000000;
			tmr_load      <= 1'b0;
			tmr_count     <= 16'h0000;
			init_started  <= 1'b0;
			hv_enable_o   <= 1'b0;
			prog_start_o  <= 1'b0;
			erase_start_o <= 1'b0;
			read_start_o  <= 1'b0;
			addr_o        <= 40'h0000000000;
		end else begin
			tmr_load      <= 1'b0;
			prog_start_o  <= 1'b0;
			erase_start_o <= 1'b0;
			read_start_o  <= 1'b0;
			// Init timer is started once after release of reset.
			if (!init_started) begin
				init_started <= 1'b1;
				tmr_load     <= 1'b1;
				tmr_count    <= INIT_CYC;
			end
			// Address cycles: only the first five are kept.
			if (addr_we_i && !busy) begin
				if (addr_cnt < `NCRG_ADDR_CYCLES) begin
					addr_buf <= {io_i, addr_buf[39:8]};
					addr_cnt <= addr_cnt + 3'd1;
				end // A sixth cycle is accepted and dropped.
			end
			// Write protect low aborts program or erase.
			if (!wp_n_i && (state == ST_PROG || state == ST_ERASE)) begin
				hv_enable_o  <= 1'b0;
				fail         <= 1'b1;
				prog_pending <= 1'b0;
				state        <= ST_DISCHARGE;
				tmr_load     <= 1'b1;
				tmr_count    <= DIS_CYC;
			end else if (cmd_we_i && io_i == `NCRG_CMD_RESET && init_started) begin
				// Reset: drop everything, discharge if high voltage is up.
				// A pending multi page program is lost too.
				prog_pending  <= 1'b0;
				status_mode   <= 1'b0;
				data_out_mode <= 1'b0;
				addr_cnt      <= 3'd0;
				tmr_load      <= 1'b1;
				if (hv_enable_o) begin
					hv_enable_o <= 1'b0;
					state       <= ST_DISCHARGE;
					tmr_count   <= DIS_CYC;
				end else begin
					state     <= ST_RST_WAIT;
					tmr_count <= RST_CYC;
				end
			end else if (cmd_we_i && busy) begin
				// Only status codes act while busy; init allows 70h only.
				if (busy_ok(io_i, state == ST_INIT)) begin
					status_mode <= 1'b1;
				end
			end else if (cmd_we_i) begin
				case (io_i)
					`NCRG_CMD_STATUS, `NCRG_CMD_STATUS2: begin
						status_mode <= 1'b1; // Stays until 00h, 80h or FFh.
					end
					`NCRG_CMD_READ: begin
						status_mode <= 1'b0;
						// Back to data output from the stopped column.
						if (status_mode && data_out_mode) begin
							data_out_mode <= 1'b1;
						end else begin
							addr_cnt <= 3'd0;
						end
						if (state == ST_SERIAL_IN) begin
							state <= ST_IDLE; // Program dropped.
						end
					end
					`NCRG_CMD_READ_CONF: begin
						addr_o        <= addr_buf;
						read_start_o  <= 1'b1;
						data_out_mode <= 1'b1;
						last_was_pe   <= 1'b0;
						state         <= ST_READ;
						tmr_load      <= 1'b1;
						tmr_count     <= READ_CYC;
					end
					`NCRG_CMD_SERIAL_IN: begin
						addr_cnt      <= 3'd0;
						data_out_mode <= 1'b0;
						status_mode   <= 1'b0;
						state         <= ST_SERIAL_IN;
					end
					`NCRG_CMD_COL_CHG: begin
						addr_cnt <= 3'd0; // New column in the same page.
					end
					`NCRG_CMD_PROG, `NCRG_CMD_MULTI: begin
						if (state == ST_SERIAL_IN) begin
							// Each segment program is a full program of its own.
							addr_o       <= addr_buf;
							prog_start_o <= 1'b1;
							hv_enable_o  <= 1'b1;
							last_was_pe  <= 1'b1;
							prog_pending <= (io_i == `NCRG_CMD_MULTI);
							state        <= ST_PROG;
							tmr_load     <= 1'b1;
							tmr_count    <= PROG_CYC;
						end
					end
					`NCRG_CMD_ERASE: begin
						addr_cnt <= 3'd0;
						if (state == ST_SERIAL_IN) begin
							state <= ST_IDLE;
						end
					end
					`NCRG_CMD_ERASE_CNF: begin
						addr_o        <= addr_buf;
						erase_start_o <= 1'b1;
						hv_enable_o   <= 1'b1;
						last_was_pe   <= 1'b1;
						state         <= ST_ERASE;
						tmr_load      <= 1'b1;
						tmr_count     <= ERASE_CYC;
					end
					default: begin
						// Unknown code: leave serial input, do nothing else.
						if (state == ST_SERIAL_IN) begin
							state <= ST_IDLE;
						end
					end
				endcase
			end else if (tmr_done && !tmr_load && init_started) begin
				// Busy period over.
				case (state)
					ST_PROG, ST_ERASE: begin
						hv_enable_o <= 1'b0;
						fail        <= array_fail_i;
						state       <= ST_IDLE;
					end
					ST_DISCHARGE: begin
						// Voltage is down: enter the wait state.
						state     <= ST_RST_WAIT;
						tmr_load  <= 1'b1;
						tmr_count <= RST_CYC;
					end
					ST_INIT, ST_READ, ST_RST_WAIT: begin
						state <= ST_IDLE;
					end
					default: begin
						state <= state;
					end
				endcase
			end
		end
	end

	// Per-unit ECC outcome: over eight bits is uncorrectable.
	always @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			uncorrectable_o <= 1'b0;
		end else if (ecc_unit_done_i && ecc_err_bits_i > `NCRG_ECC_MAX_BITS) begin
			// A failing unit wins over a new read start, so no error is lost.
			uncorrectable_o <= 1'b1;
		end else if (read_start_o) begin
			uncorrectable_o <= 1'b0;
		end
	end

	// Column counter for data output; frozen while status is shown.
	always @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			column_o <= 12'h000;
		end else if (read_start_o) begin
			column_o <= {addr_buf[11:8], addr_buf[7:0]};
		end else if (data_re_i && data_out_mode && !status_mode && !busy) begin
			column_o <= column_o + 12'h001;
		end
	end

	// Pin outputs: open-drain busy, and the data bus.
	always @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ready_busy_n_oe_o <= 1'b1; // Busy from reset on.
			io_o              <= 8'h00;
			io_oe_o           <= 1'b0;
		end else begin
			ready_busy_n_oe_o <= busy || !init_started;
			io_oe_o           <= data_re_i;
			if (status_mode) begin
				io_o <= status_byte(busy, fail & last_was_pe, wp_n_i);
			end else begin
				io_o <= 8'h00;
			end
		end
	end

endmodule // ncrg_guard

`default_nettype wire

//--- tb/ncrg_guard_props.sv
`default_nettype none
// Port-level checks of the command guard.
module ncrg_guard_props (
	// Clock and reset.
	input wire logic        core_clk_i,
	input wire logic        nrst_i,
	// Bus and pins.
	input wire logic        cmd_we_i,
	input wire logic        addr_we_i,
	input wire logic        data_re_i,
	input wire logic [7:0]  io_i,
	input wire logic        wp_n_i,
	input wire logic [3:0]  ecc_err_bits_i,
	input wire logic        ecc_unit_done_i,
	// Outputs.
	input wire logic [7:0]  io_o,
	input wire logic        io_oe_o,
	input wire logic        ready_busy_n_oe_o,
	input wire logic        hv_enable_o,
	input wire logic        prog_start_o,
	input wire logic        erase_start_o,
	input wire logic        read_start_o,
	input wire logic [39:0] addr_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!nrst_i);
	logic [2:0] addr_cnt; // Address cycles since the last command; saturates so it never wraps.
	// Count address cycles so the sixth and later can be singled out.
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			addr_cnt <= 3'h0;
		end else if (cmd_we_i) begin
			addr_cnt <= 3'h0;
		end else if (addr_we_i && addr_cnt != 3'h7) begin
			addr_cnt <= addr_cnt + 3'h1;
		end
	end
	logic [39:0] addr_ref; // First five address bytes since the last command, first byte lowest.
	// Reference copy of the address that a program must use; later cycles are left out.
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			addr_ref <= 40'h0000000000;
		end else if (addr_we_i && addr_cnt < 3'h5) begin
			addr_ref <= {io_i, addr_ref[39:8]};
		end
	end
	init_busy_a: assert property ($rose(nrst_i) |-> ready_busy_n_oe_o [*8])
		else $error("busy missing in init");
	reset_busy_a: assert property (cmd_we_i && io_i == 8'hff |-> ##2 ready_busy_n_oe_o)
		else $error("reset not busy");
	reset_hv_a: assert property (cmd_we_i && io_i == 8'hff && hv_enable_o |-> ##[1:30] !hv_enable_o)
		else $error("high voltage kept");
	wp_abort_a: assert property (!wp_n_i && hv_enable_o |-> ##[1:30] !hv_enable_o)
		else $error("no abort on wp");
	busy_gate_a: assert property (cmd_we_i && ready_busy_n_oe_o |=> !(prog_start_o || erase_start_o || read_start_o))
		else $error("start while busy");
	prog_cause_a: assert property (prog_start_o |-> hv_enable_o && $past(cmd_we_i) &&
		($past(io_i) == 8'h10 || $past(io_i) == 8'h11))
		else $error("bad program start");
	addr_drop_a: assert property (addr_we_i && addr_cnt >= 3'h5 |=> $stable(addr_o))
		else $error("sixth address used");
	addr_keep_a: assert property (prog_start_o |-> addr_o == addr_ref)
		else $error("program address wrong");
	read_oe_a: assert property (data_re_i |=> io_oe_o)
		else $error("no output drive");
	busy_pf_a: assert property (io_oe_o && ready_busy_n_oe_o |-> io_o[0] == 1'b0)
		else $error("fail bit while busy");
	cover property (prog_start_o);
	cover property (erase_start_o);
	cover property (read_start_o);
	cover property (ecc_unit_done_i && ecc_err_bits_i > 4'h8);
endmodule // ncrg_guard_props
bind ncrg_guard ncrg_guard_props ncrg_guard_props_inst (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
	.cmd_we_i(cmd_we_i), .addr_we_i(addr_we_i), .data_re_i(data_re_i), .io_i(io_i), .wp_n_i(wp_n_i),
	.ecc_err_bits_i(ecc_err_bits_i), .ecc_unit_done_i(ecc_unit_done_i), .io_o(io_o), .io_oe_o(io_oe_o),
	.ready_busy_n_oe_o(ready_busy_n_oe_o), .hv_enable_o(hv_enable_o), .prog_start_o(prog_start_o),
	.erase_start_o(erase_start_o), .read_start_o(read_start_o), .addr_o(addr_o));
`default_nettype wire

//--- tb/ncrg_ctl_model.sv
`default_nettype none
// Controller model: one bus cycle per call, launched and ended on falling edges.
module ncrg_ctl_model (
	// Clock.
	input  wire logic       core_clk_i,
	// Bus towards the device.
	output var  logic       cmd_we_o,
	output var  logic       addr_we_o,
	output var  logic       re_o,
	output var  logic [7:0] io_o,
	output var  logic       wp_n_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Power comes up with write protect held low.
	initial begin
		cmd_we_o = 1'b0;
		addr_we_o = 1'b0;
		re_o = 1'b0;
		io_o = 8'h00;
		wp_n_o = 1'b0;
	end
	// Kind 0 is a command, 1 an address, 2 a read; callers send only listed codes.
	task automatic cyc(input logic [1:0] k, input logic [7:0] b);
		@(negedge core_clk_i);
		cmd_we_o = (k == 2'd0);
		addr_we_o = (k == 2'd1);
		re_o = (k == 2'd2);
		io_o = b;
		@(negedge core_clk_i);
		cmd_we_o = 1'b0;
		addr_we_o = 1'b0;
		re_o = 1'b0;
		io_o = ~b; // A released bus must not keep showing the last byte.
	endtask
endmodule // ncrg_ctl_model
`default_nettype wire

//--- tb/ncrg_testbench.sv
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin num_errors++; $display("[FAIL] %0t got %h want %h", $time, a, b); end end
// Drives the guard through the controller model and checks status bytes in order.
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        core_clk_i, nrst_i, wp_n, cmd_we, addr_we, data_re, fail, ecc_done;
	logic [7:0]  io_in;
	logic [3:0]  ecc_bits;
	wire  [7:0]  io_out;
	wire  [39:0] addr;
	wire  [11:0] col;
	wire         io_oe, busy, hv, ps, es, rs, unc;
	logic [7:0]  exp_q[$]; // Driven bytes expected (status and page data), oldest first.
	logic [7:0]  ab[6];    // Address bytes of the current operation.
	logic [7:0]  exp_byte; // Oldest note, taken off the queue before it is compared.
	int          num_errors, checks_done, cycles;
	ncrg_ctl_model ctl (.core_clk_i(core_clk_i), .cmd_we_o(cmd_we), .addr_we_o(addr_we), .re_o(data_re),
		.io_o(io_in), .wp_n_o(wp_n));
	ncrg_guard ncrg_guard_inst (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .cmd_we_i(cmd_we), .addr_we_i(addr_we),
		.data_we_i(1'b0), .data_re_i(data_re), .io_i(io_in), .wp_n_i(wp_n), .array_fail_i(fail),
		.ecc_err_bits_i(ecc_bits), .ecc_unit_done_i(ecc_done), .io_o(io_out), .io_oe_o(io_oe),
		.ready_busy_n_oe_o(busy), .hv_enable_o(hv), .prog_start_o(ps), .erase_start_o(es),
		.read_start_o(rs), .addr_o(addr), .column_o(col), .uncorrectable_o(unc));
	// Free-running clock, 4 ns period.
	initial begin
		core_clk_i = 1'b0;
		forever #2 core_clk_i = ~core_clk_i;
	end
	// Every driven byte leaves the queue in the order it was noted.
	always @(negedge core_clk_i) begin
		if (io_oe === 1'b1) begin
			`CHK(exp_q.size() != 0, 1'b1)
			if (exp_q.size() != 0) begin
				exp_byte = exp_q.pop_front();
				`CHK(io_out, exp_byte)
			end
		end
	end
	// Cut a hang short; the ceiling is several times the expected run.
	always @(posedge core_clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			close_out();
		end
	end
	task automatic close_out;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// Status command, then one read whose byte is noted first.
	task automatic st(input logic [7:0] e);
		exp_q.push_back(e);
		ctl.cyc(2'd0, 8'h70);
		ctl.cyc(2'd2, 8'h00);
	endtask
	task automatic op(input logic [7:0] c0, input int n, input logic [7:0] c1);
		ctl.cyc(2'd0, c0);
		for (int i = 0; i < n; i++) ctl.cyc(2'd1, ab[i]);
		ctl.cyc(2'd0, c1);
	endtask
	// Busy starts two cycles after a command, so give it time before polling.
	task automatic wait_ready;
		int n;
		n = 0;
		repeat (3) @(negedge core_clk_i);
		while (busy !== 1'b0 && n < 3000) begin
			@(negedge core_clk_i);
			n++;
		end
		`CHK(busy, 1'b0)
	endtask
	task automatic ecc(input logic [3:0] b);
		@(negedge core_clk_i);
		ecc_bits = b;
		ecc_done = 1'b1;
		@(negedge core_clk_i);
		ecc_done = 1'b0;
	endtask
	initial begin
		void'($urandom(32'h5d1c));
		{nrst_i, fail, ecc_done, ecc_bits, num_errors, checks_done} = '0;
		repeat (2) @(negedge core_clk_i);
		nrst_i = 1'b1;
		repeat (2) @(negedge core_clk_i);
		st(8'h00);
		wait_ready;
		st(8'h60);
		ctl.wp_n_o = 1'b1;
		$display("test init done");
		foreach (ab[i]) ab[i] = 8'($urandom);
		fail = 1'($urandom);
		op(8'h80, 6, 8'h10);
		`CHK(addr, {ab[4], ab[3], ab[2], ab[1], ab[0]})
		st(8'h80);
		exp_q.push_back(8'h80);
		ctl.cyc(2'd0, 8'h71);
		ctl.cyc(2'd2, 8'h00);
		wait_ready;
		st(8'he0 | {7'h0, fail});
		ab[3] = ab[3] ^ {7'h0, fail}; // A failed block is retired and the data goes elsewhere.
		ab[2] = ab[2] + 8'h01; // Pages of a block are written lowest first.
		fail = 1'b0;
		$display("test program done");
		// Multi page program, cut short by the reset below.
		op(8'h80, 5, 8'h11);
		repeat (20) @(negedge core_clk_i);
		ctl.cyc(2'd0, 8'hff);
		repeat (100) @(negedge core_clk_i);
		`CHK(hv, 1'b0)
		ctl.cyc(2'd0, 8'hff);
		repeat (100) @(negedge core_clk_i);
		`CHK(busy, 1'b1)
		wait_ready;
		$display("test reset done");
		// Only a block that the bench treats as good is erased.
		op(8'h60, 3, 8'hd0);
		`CHK(hv, 1'b1)
		repeat (20) @(negedge core_clk_i);
		ctl.wp_n_o = 1'b0;
		wait_ready;
		st(8'h61);
		ctl.wp_n_o = 1'b1;
		op(8'h80, 5, 8'h00);
		repeat (4) @(negedge core_clk_i);
		`CHK(busy, 1'b0)
		ctl.cyc(2'd0, 8'h10); // A confirm with no serial input pending must start nothing.
		`CHK(hv, 1'b0)
		$display("test abort done");
		// One column of one page is read, as a bad-block scan would do.
		op(8'h00, 5, 8'h30);
		ecc(4'($urandom_range(8)));
		`CHK(unc, 1'b0)
		ecc(4'($urandom_range(15, 9)));
		`CHK(unc, 1'b1)
		wait_ready;
		// Pass/fail only follows program or erase, so a read leaves it clear.
		st(8'he0);
		exp_q.push_back(8'he0);
		ctl.cyc(2'd2, 8'h00);
		ctl.cyc(2'd0, 8'h00);
		`CHK(col, {ab[1][3:0], ab[0]})
		exp_q.push_back(8'h00);
		ctl.cyc(2'd2, 8'h00);
		`CHK(col, {ab[1][3:0], ab[0]} + 12'h001)
		$display("test read done");
		repeat (2) @(negedge core_clk_i);
		`CHK(exp_q.size(), 0)
		close_out();
	end
endmodule // testbench
`default_nettype wire
